// ---- wsac_core.sv ----
// search accelerator and configuration parameter core
//
// Overview of operation
// - with accelerator on in data mode a pass is 16 bytes, 4 positions each.
// - each identifier position runs two read slots then one write slot.
// - write host path on conflict, first read otherwise, 1 on no response.
// - 16 response bytes per pass, even bit discrepancy, odd bit taken path.
// - discrepancy is 1 on conflict or no response, else 0.
// - reported taken bit equals the value of the write slot until a bus error.
// - after a bus error all later taken bits read 1 until accelerator off.
// - B1 turns accelerator on, A1 off, in command mode, no response.
// - E1 enters data mode, E3 returns to command mode, no response.
// - reset loads hard-wired defaults into every configuration parameter.
// - defaults 524ms pullup, 3mA load threshold, 9.6kbps at every speed.
// - write-1 low default 8us regular or flexible, 1us overdrive.
// - parameter picked by 3-bit code, holds one of eight value codes.
// - slew, write-1 low and sample offset only act at flexible speed.
// - one parameter sets both sample delay and write-0 recovery time.
// - load sensor works only when pullup duration holds the dynamic code.
// - config byte bit7 0, bit0 1; write or read layout of codes.
// - config answer bit0 0, echo upper bits, read returns value in 3..1.
// - accelerator command bit 4 gives the new flag, no response byte.
`timescale 1ns/10ps
module wsac_core
    import wsac_pkg::*;
(
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // host byte stream in
    input wire logic [7:0] RX_DATA,
    input wire logic RX_VALID,
    output logic RX_READY,
    // response byte stream out
    output logic [7:0] TX_DATA,
    output logic TX_VALID,
    input wire logic TX_READY,
    // time slot engine
    output logic SLOT_REQ,
    output logic SLOT_WR,
    output logic SLOT_WBIT,
    input wire logic SLOT_DONE,
    input wire logic SLOT_RBIT,
    // configuration to waveform and interface logic
    output wsac_cfg_s CFG_CODES,
    output wsac_wave_s WAVE
);
    wsac_state_e state;
    wsac_speed_e speed;
    logic data_mode;
    logic acc_on;
    logic err_sticky;
    logic [7:0] cur_byte;
    logic [7:0] resp_byte;
    logic [1:0] pos;
    logic [1:0] slot;
    logic [3:0] byte_cnt;
    logic rd_first;
    logic rd_second;
    wsac_cfg_s cfg;
    logic [2:0] cfg_rd_val;
    logic rx_take;
    logic is_cfg;
    logic is_cfg_read;
    logic [2:0] par_code;
    logic dec_write;
    logic dec_disc;
    logic dec_taken;
    logic dec_err;
    logic path_bit;
    logic wb_req;
    logic [31:0] next_rdata;

    assign rx_take = RX_VALID & RX_READY;
    assign is_cfg = (RX_DATA & CFG_CMD_MASK) == CFG_CMD_CODE;
    assign is_cfg_read = RX_DATA[6:4] == 3'h0;
    assign par_code = is_cfg_read ? RX_DATA[3:1] : RX_DATA[6:4];
    // odd bit of each pair carries the path, even bit is filler
    assign path_bit = cur_byte[{pos, 1'b1}];

    wsac_bit_decide u_decide (
        .first_read_slot(rd_first),
        .second_read_slot(rd_second),
        .path(path_bit),
        .err_in(err_sticky),
        .search_write_slot(dec_write),
        .disc(dec_disc),
        .taken(dec_taken),
        .err_out(dec_err)
    );

    always_comb begin
        case (par_code)
            PAR_SLEW: cfg_rd_val = cfg.slew;
            PAR_PROG: cfg_rd_val = cfg.prog;
            PAR_SPU: cfg_rd_val = cfg.spu;
            PAR_W1LT: cfg_rd_val = cfg.w1lt;
            PAR_DSO: cfg_rd_val = cfg.dso;
            PAR_LOAD: cfg_rd_val = cfg.load;
            PAR_BAUD: cfg_rd_val = cfg.baud;
            default: cfg_rd_val = 3'h0;
        endcase
    end

    // mode and accelerator flag; config bytes never touch them
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            data_mode <= 1'b0;
            acc_on <= 1'b0;
        end else if (rx_take) begin
            if (data_mode) begin
                if (RX_DATA == CMD_CMD_MODE) begin
                    data_mode <= 1'b0;
                end
            end else if (RX_DATA == CMD_DATA_MODE) begin
                data_mode <= 1'b1;
            end else if ((RX_DATA & ACC_CMD_MASK) == ACC_CMD_CODE) begin
                acc_on <= RX_DATA[ACC_FLAG_BIT];
            end
        end
    end

    // parameter store, defaults on reset
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            cfg.slew <= DEF_SLEW;
            cfg.prog <= DEF_PROG;
            cfg.spu <= DEF_SPU;
            cfg.w1lt <= DEF_W1LT;
            cfg.dso <= DEF_DSO;
            cfg.load <= DEF_LOAD;
            cfg.baud <= DEF_BAUD;
        end else if (rx_take && !data_mode && is_cfg && !is_cfg_read) begin
            case (par_code)
                PAR_SLEW: cfg.slew <= RX_DATA[3:1];
                PAR_PROG: cfg.prog <= RX_DATA[3:1];
                PAR_SPU: cfg.spu <= RX_DATA[3:1];
                PAR_W1LT: cfg.w1lt <= RX_DATA[3:1];
                PAR_DSO: cfg.dso <= RX_DATA[3:1];
                PAR_LOAD: cfg.load <= RX_DATA[3:1];
                default: cfg.baud <= RX_DATA[3:1];
            endcase
        end
    end

    // search sequencer
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            state <= ST_IDLE;
            cur_byte <= 8'h00;
            resp_byte <= 8'h00;
            pos <= 2'h0;
            slot <= SLOT_FIRST_READ;
            byte_cnt <= 4'h0;
            rd_first <= 1'b0;
            rd_second <= 1'b0;
            err_sticky <= 1'b0;
            SLOT_REQ <= 1'b0;
            SLOT_WR <= 1'b0;
            SLOT_WBIT <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (!acc_on) begin
                        err_sticky <= 1'b0;
                        byte_cnt <= 4'h0;
                    end
                    if (rx_take && data_mode && acc_on &&
                        RX_DATA != CMD_CMD_MODE) begin
                        cur_byte <= RX_DATA;
                        pos <= 2'h0;
                        slot <= SLOT_FIRST_READ;
                        SLOT_REQ <= 1'b1;
                        SLOT_WR <= 1'b0;
                        SLOT_WBIT <= 1'b1;
                        state <= ST_SLOT;
                    end
                end
                ST_SLOT: begin
                    if (SLOT_DONE) begin
                        SLOT_REQ <= 1'b0;
                        if (slot == SLOT_FIRST_READ) begin
                            rd_first <= SLOT_RBIT;
                            slot <= SLOT_SECOND_READ;
                            state <= ST_DECIDE;
                        end else if (slot == SLOT_SECOND_READ) begin
                            rd_second <= SLOT_RBIT;
                            slot <= SLOT_WRITE;
                            state <= ST_DECIDE;
                        end else begin
                            slot <= SLOT_FIRST_READ;
                            if (pos == POS_PER_BYTE_LAST) begin
                                state <= ST_RESP;
                            end else begin
                                pos <= pos + 2'h1;
                                state <= ST_DECIDE;
                            end
                        end
                    end
                end
                ST_DECIDE: begin
                    // one idle cycle lets the read value settle into the decision
                    SLOT_REQ <= 1'b1;
                    if (slot == SLOT_WRITE) begin
                        SLOT_WR <= 1'b1;
                        SLOT_WBIT <= dec_write;
                        resp_byte[{pos, 1'b0}] <= dec_disc;
                        resp_byte[{pos, 1'b1}] <= dec_taken;
                        err_sticky <= dec_err;
                    end else begin
                        SLOT_WR <= 1'b0;
                        SLOT_WBIT <= 1'b1;
                    end
                    state <= ST_SLOT;
                end
                default: begin
                    if (!TX_VALID) begin
                        byte_cnt <= (byte_cnt == BYTES_PER_PASS_LAST)
                            ? 4'h0 : byte_cnt + 4'h1;
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // response stream; RX_READY holds off the next byte until the host drains it
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            TX_VALID <= 1'b0;
            TX_DATA <= 8'h00;
        end else if (TX_VALID) begin
            if (TX_READY) begin
                TX_VALID <= 1'b0;
            end
        end else if (state == ST_RESP) begin
            TX_VALID <= 1'b1;
            TX_DATA <= resp_byte;
        end else if (rx_take && !data_mode && is_cfg) begin
            TX_VALID <= 1'b1;
            TX_DATA <= is_cfg_read ? {RX_DATA[7:4], cfg_rd_val, 1'b0}
                : {RX_DATA[7:1], 1'b0};
        end else if (rx_take && data_mode && !acc_on &&
            RX_DATA != CMD_CMD_MODE) begin
            // plain data bytes are echoed, no bus activity here
            TX_VALID <= 1'b1;
            TX_DATA <= RX_DATA;
        end
    end

    // accept a byte only with nothing pending downstream
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            RX_READY <= 1'b0;
        end else begin
            RX_READY <= (state == ST_IDLE) && !TX_VALID && !rx_take;
        end
    end

    // waveform settings as seen by the slot timing logic
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            CFG_CODES <= '0;
            WAVE <= '0;
        end else begin
            CFG_CODES <= cfg;
            WAVE.load_sense_en <= cfg.spu == SPU_DYNAMIC;
            WAVE.w0rec_us <= W0R_BASE_US;
            if (speed == SPEED_FLEXIBLE) begin
                WAVE.slew <= cfg.slew;
                WAVE.w1lt_us <= W1LT_BASE_US + {2'h0, cfg.w1lt};
                WAVE.sample_us <= DSO_BASE_US + {2'h0, cfg.dso};
                WAVE.w0rec_us <= W0R_BASE_US + {2'h0, cfg.dso};
            end else if (speed == SPEED_OVERDRIVE) begin
                WAVE.slew <= DEF_SLEW;
                WAVE.w1lt_us <= W1LT_OD_US;
                WAVE.sample_us <= DSO_OD_US;
            end else begin
                WAVE.slew <= DEF_SLEW;
                WAVE.w1lt_us <= W1LT_BASE_US;
                WAVE.sample_us <= DSO_BASE_US;
            end
        end
    end

    // wishbone slave, one wait state, ack drops the cycle after
    assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;

    always_comb begin
        if (WB_ADR_I == REG_CTRL) begin
            next_rdata = {30'h0, speed};
        end else if (WB_ADR_I == REG_STATUS) begin
            next_rdata = {20'h0, byte_cnt, pos, state, 1'b0,
                err_sticky, acc_on, data_mode};
        end else if (WB_ADR_I == REG_CFG) begin
            next_rdata = {11'h0, cfg};
        end else begin
            next_rdata = 32'h0;
        end
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0;
            speed <= SPEED_REGULAR;
        end else begin
            WB_ACK_O <= wb_req;
            WB_DAT_O <= (wb_req && !WB_WE_I) ? next_rdata : 32'h0;
            if (wb_req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == REG_CTRL &&
                WB_DAT_I[1:0] != 2'h3) begin
                speed <= wsac_speed_e'(WB_DAT_I[1:0]);
            end
        end
    end
endmodule

// ---- wsac_pkg.sv ----
// constants and types shared by the search accelerator and configuration core
package wsac_pkg;

    // host command codes
    localparam logic [7:0] CMD_DATA_MODE = 8'hE1;
    localparam logic [7:0] CMD_CMD_MODE = 8'hE3;
    localparam logic [7:0] ACC_CMD_MASK = 8'hEF;
    localparam logic [7:0] ACC_CMD_CODE = 8'hA1;
    localparam int ACC_FLAG_BIT = 4;
    localparam logic [7:0] CFG_CMD_MASK = 8'h81;
    localparam logic [7:0] CFG_CMD_CODE = 8'h01;

    // search pass shape
    localparam logic [1:0] POS_PER_BYTE_LAST = 2'h3;
    localparam logic [3:0] BYTES_PER_PASS_LAST = 4'hF;
    localparam logic [1:0] SLOT_FIRST_READ = 2'h0;
    localparam logic [1:0] SLOT_SECOND_READ = 2'h1;
    localparam logic [1:0] SLOT_WRITE = 2'h2;

    // parameter codes
    localparam logic [2:0] PAR_SLEW = 3'h1;
    localparam logic [2:0] PAR_PROG = 3'h2;
    localparam logic [2:0] PAR_SPU = 3'h3;
    localparam logic [2:0] PAR_W1LT = 3'h4;
    localparam logic [2:0] PAR_DSO = 3'h5;
    localparam logic [2:0] PAR_LOAD = 3'h6;
    localparam logic [2:0] PAR_BAUD = 3'h7;

    // values after power-up or master reset
    localparam logic [2:0] DEF_SLEW = 3'h0;
    localparam logic [2:0] DEF_PROG = 3'h4;
    localparam logic [2:0] DEF_SPU = 3'h4;
    localparam logic [2:0] DEF_W1LT = 3'h0;
    localparam logic [2:0] DEF_DSO = 3'h0;
    localparam logic [2:0] DEF_LOAD = 3'h4;
    localparam logic [2:0] DEF_BAUD = 3'h0;
    localparam logic [2:0] SPU_DYNAMIC = 3'h6;

    // waveform times in microseconds
    localparam logic [4:0] W1LT_BASE_US = 5'h08;
    localparam logic [4:0] W1LT_OD_US = 5'h01;
    localparam logic [4:0] DSO_BASE_US = 5'h03;
    localparam logic [4:0] DSO_OD_US = 5'h01;
    localparam logic [4:0] W0R_BASE_US = 5'h03;

    // wishbone register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CFG = 8'h08;
    localparam logic [1:0] CTRL_SPEED_RESET = 2'h0;

    typedef enum logic [1:0] {
        SPEED_REGULAR = 2'b00,
        SPEED_FLEXIBLE = 2'b01,
        SPEED_OVERDRIVE = 2'b10
    } wsac_speed_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SLOT = 2'b01,
        ST_DECIDE = 2'b10,
        ST_RESP = 2'b11
    } wsac_state_e;

    typedef struct packed {
        logic [2:0] slew;
        logic [2:0] prog;
        logic [2:0] spu;
        logic [2:0] w1lt;
        logic [2:0] dso;
        logic [2:0] load;
        logic [2:0] baud;
    } wsac_cfg_s;

    typedef struct packed {
        logic [4:0] w1lt_us;
        logic [4:0] sample_us;
        logic [4:0] w0rec_us;
        logic [2:0] slew;
        logic load_sense_en;
    } wsac_wave_s;

endpackage

// ---- wsac_bit_decide.sv ----
// path decision for one identifier bit position of a search pass
`timescale 1ns/10ps
module wsac_bit_decide
    import wsac_pkg::*;
(
    // read slot results and host choice
    input wire logic first_read_slot,
    input wire logic second_read_slot,
    input wire logic path,
    input wire logic err_in,
    // decision
    output logic search_write_slot,
    output logic disc,
    output logic taken,
    output logic err_out
);
    logic conflict;
    logic no_resp;

    assign conflict = ~first_read_slot & ~second_read_slot;
    assign no_resp = first_read_slot & second_read_slot;
    // host path on conflict, forced 1 with no answer, else the only path
    assign search_write_slot = conflict ? path
        : (no_resp ? 1'b1 : first_read_slot);
    assign disc = conflict | no_resp;
    assign err_out = err_in | no_resp;
    // once an error is seen every later taken bit reads 1
    assign taken = err_out ? 1'b1 : search_write_slot;
endmodule

// ---- wsac_core_props.sv ----
// concurrent checks on the accelerator core ports
`timescale 1ns/10ps
module wsac_core_props
    import wsac_pkg::*;
(
    // clock, reset, register bus
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    input wire logic [31:0] WB_DAT_O,
    // byte streams
    input wire logic RX_VALID,
    input wire logic RX_READY,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_VALID,
    input wire logic TX_READY,
    // slot engine and configuration
    input wire logic SLOT_REQ,
    input wire logic SLOT_WR,
    input wire logic SLOT_WBIT,
    input wire logic SLOT_DONE,
    input wire logic SLOT_RBIT,
    input wsac_cfg_s CFG_CODES,
    input wsac_wave_s WAVE
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    logic [1:0] slot_cnt;
    logic r0;
    logic r1;
    // counts finished slots; a pass is always whole, so mod 3 stays aligned
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            slot_cnt <= 2'h0;
        end else if (SLOT_REQ && SLOT_DONE) begin
            slot_cnt <= (slot_cnt == 2'h2) ? 2'h0 : slot_cnt + 2'h1;
        end
    end
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            r0 <= 1'b0;
            r1 <= 1'b0;
        end else if (SLOT_REQ && SLOT_DONE && slot_cnt == 2'h0) begin
            r0 <= SLOT_RBIT;
        end else if (SLOT_REQ && SLOT_DONE && slot_cnt == 2'h1) begin
            r1 <= SLOT_RBIT;
        end
    end
    sequence s_wb_req;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence s_ack_pulse;
        WB_ACK_O ##1 !WB_ACK_O;
    endsequence
    a_wb_ack_pulse: assert property (s_wb_req |=> s_ack_pulse)
        else $error("ack is not one pulse after a request");
    a_dat_idle_zero: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
        else $error("read data not zero outside ack");
    a_cfg_reset_defaults: assert property ($fell(SYS_RST) |=>
        CFG_CODES == {DEF_SLEW, DEF_PROG, DEF_SPU, DEF_W1LT, DEF_DSO,
        DEF_LOAD, DEF_BAUD}) else $error("codes not default after reset");
    a_load_sense_gate: assert property ($stable(CFG_CODES) |->
        WAVE.load_sense_en == (CFG_CODES.spu == SPU_DYNAMIC))
        else $error("load sensor enable wrong");
    a_slot_triplet: assert property (SLOT_REQ && !$past(SLOT_DONE) |->
        SLOT_WR == (slot_cnt == 2'h2)) else $error("slot order wrong");
    a_write_decision: assert property (SLOT_REQ && SLOT_WR &&
        slot_cnt == 2'h2 && (r0 || r1) |-> SLOT_WBIT == r0)
        else $error("write slot value wrong");
    a_slot_req_hold: assert property (SLOT_REQ && !SLOT_DONE |=>
        SLOT_REQ && $stable(SLOT_WR) && $stable(SLOT_WBIT))
        else $error("slot request not held");
    a_tx_hold: assert property (TX_VALID && !TX_READY |=>
        TX_VALID && $stable(TX_DATA)) else $error("response not held");
    a_rx_gap: assert property (RX_VALID && RX_READY |=> !RX_READY)
        else $error("byte taken on consecutive cycles");
endmodule
bind wsac_core wsac_core_props u_props (.CLK_SYS(CLK_SYS),
    .SYS_RST(SYS_RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O), .RX_VALID(RX_VALID),
    .RX_READY(RX_READY), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
    .TX_READY(TX_READY), .SLOT_REQ(SLOT_REQ), .SLOT_WR(SLOT_WR),
    .SLOT_WBIT(SLOT_WBIT), .SLOT_DONE(SLOT_DONE), .SLOT_RBIT(SLOT_RBIT),
    .CFG_CODES(CFG_CODES), .WAVE(WAVE));

// ---- wsac_slave_model.sv ----
// behavioural bus devices answering read and write time slots
`timescale 1ns/10ps
module wsac_slave_model (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    // slot handshake
    input wire logic SLOT_REQ,
    input wire logic SLOT_WR,
    input wire logic SLOT_WBIT,
    output logic SLOT_DONE,
    output logic SLOT_RBIT,
    // per position read pairs, answer delay, record of writes
    input wire logic [127:0] READS,
    input wire logic [3:0] DELAY,
    output logic [63:0] WROTE
);
    logic [3:0] wait_cnt;
    logic armed;
    logic second;
    logic [5:0] pos;
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            SLOT_DONE <= 1'b0;
            SLOT_RBIT <= 1'b1;
            WROTE <= 64'h0;
            wait_cnt <= 4'h0;
            armed <= 1'b1;
            second <= 1'b0;
            pos <= 6'h0;
        end else begin
            SLOT_DONE <= 1'b0;
            // released bus line floats high on its pull-up
            SLOT_RBIT <= 1'b1;
            if (!SLOT_REQ) begin
                armed <= 1'b1;
            end else if (armed && wait_cnt != DELAY) begin
                wait_cnt <= wait_cnt + 4'h1;
            end else if (armed) begin
                wait_cnt <= 4'h0;
                armed <= 1'b0;
                SLOT_DONE <= 1'b1;
                if (SLOT_WR) begin
                    WROTE[pos] <= SLOT_WBIT;
                    pos <= pos + 6'h1;
                    second <= 1'b0;
                end else begin
                    SLOT_RBIT <= READS[{pos, second}];
                    second <= 1'b1;
                end
            end
        end
    end
endmodule

// ---- wire_search_accel_config_bench.sv ----
// self-checking bench for the search accelerator and configuration core
`timescale 1ns/10ps
module wire_search_accel_config_bench;
    import wsac_pkg::*;
    localparam wsac_cfg_s CFG_DEF = {DEF_SLEW, DEF_PROG, DEF_SPU, DEF_W1LT,
        DEF_DSO, DEF_LOAD, DEF_BAUD};
    localparam wsac_wave_s WAVE_REG = {W1LT_BASE_US, DSO_BASE_US,
        W0R_BASE_US, 3'h0, 1'b0};
    logic CLK_SYS, SYS_RST, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
    logic [7:0] WB_ADR_I, RX_DATA, TX_DATA;
    logic [3:0] WB_SEL_I, delay;
    logic [31:0] WB_DAT_I, WB_DAT_O;
    logic RX_VALID, RX_READY, TX_VALID, TX_READY, SLOT_REQ, SLOT_WR;
    logic SLOT_WBIT, SLOT_DONE, SLOT_RBIT;
    logic [127:0] reads;
    logic [63:0] wrote;
    wsac_cfg_s CFG_CODES;
    wsac_wave_s WAVE;
    int errors, n_checks;
    wsac_core DUT (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
        .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
        .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
        .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .RX_DATA(RX_DATA),
        .RX_VALID(RX_VALID), .RX_READY(RX_READY), .TX_DATA(TX_DATA),
        .TX_VALID(TX_VALID), .TX_READY(TX_READY), .SLOT_REQ(SLOT_REQ),
        .SLOT_WR(SLOT_WR), .SLOT_WBIT(SLOT_WBIT), .SLOT_DONE(SLOT_DONE),
        .SLOT_RBIT(SLOT_RBIT), .CFG_CODES(CFG_CODES), .WAVE(WAVE));
    wsac_slave_model u_bus (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
        .SLOT_REQ(SLOT_REQ), .SLOT_WR(SLOT_WR), .SLOT_WBIT(SLOT_WBIT),
        .SLOT_DONE(SLOT_DONE), .SLOT_RBIT(SLOT_RBIT), .READS(reads),
        .DELAY(delay), .WROTE(wrote));
    initial begin
        CLK_SYS = 1'b0;
        forever #12.5 CLK_SYS = ~CLK_SYS;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        int i;
        {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} <= {2'h3, we, a, d};
        i = 0;
        do begin
            @(posedge CLK_SYS);
            i++;
        end while (WB_ACK_O !== 1'b1 && i < 100);
        if (WB_ACK_O !== 1'b1) errors++;
        q = WB_DAT_O;
        {WB_CYC_I, WB_STB_I} <= 2'h0;
        @(posedge CLK_SYS);
    endtask
    task send(input logic [7:0] b);
        int i;
        @(posedge CLK_SYS);
        RX_DATA <= b;
        RX_VALID <= 1'b1;
        i = 0;
        do begin
            @(posedge CLK_SYS);
            i++;
        end while (RX_READY !== 1'b1 && i < 2000);
        if (RX_READY !== 1'b1) errors++;
        RX_VALID <= 1'b0;
    endtask
    // far side stalls two cycles before taking each response
    task xfer(input logic [7:0] b, input logic [7:0] exp);
        int i;
        send(b);
        for (i = 0; TX_VALID !== 1'b1 && i < 2000; i++) @(posedge CLK_SYS);
        if (TX_VALID !== 1'b1) errors++;
        repeat (2) @(posedge CLK_SYS);
        TX_READY <= 1'b1;
        @(posedge CLK_SYS);
        check({24'h0, TX_DATA}, {24'h0, exp});
        TX_READY <= 1'b0;
    endtask
    task cmd(input logic [7:0] b);
        send(b);
        repeat (4) @(posedge CLK_SYS);
        check({31'h0, TX_VALID}, 32'h0);
    endtask
    task speed(input logic [1:0] s, input wsac_wave_s exp);
        logic [31:0] q;
        wb(1'b1, REG_CTRL, {30'h0, s}, q);
        repeat (2) @(posedge CLK_SYS);
        check({13'h0, WAVE}, {13'h0, exp});
    endtask
    function automatic logic [1:0] rd(input int n, input int e);
        if (n == e) return 2'b11;
        return (n % 3 == 0) ? 2'b00 : ((n % 3 == 1) ? 2'b01 : 2'b10);
    endfunction
    task t_reset;
        logic [31:0] q;
        SYS_RST <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        SYS_RST <= 1'b0;
        repeat (3) @(posedge CLK_SYS);
        check({11'h0, CFG_CODES}, {11'h0, CFG_DEF});
        check({13'h0, WAVE}, {13'h0, WAVE_REG});
        wb(1'b0, REG_CFG, 32'h0, q);
        check(q, {11'h0, CFG_DEF});
        wb(1'b1, 8'h0C, 32'hFFFFFFFF, q);
        wb(1'b0, 8'h0C, 32'h0, q);
        check(q, 32'h0);
        speed(2'h2, {W1LT_OD_US, DSO_OD_US, W0R_BASE_US, 3'h0, 1'b0});
        speed(2'h1, WAVE_REG);
        speed(2'h0, WAVE_REG);
        $display("reset defaults test done");
    endtask
    task t_cfg;
        logic [2:0] v;
        logic [31:0] q;
        wsac_cfg_s e;
        int p;
        e = CFG_DEF;
        cmd(8'hB1);
        for (p = 1; p < 8; p++) begin
            v = (p == 3) ? SPU_DYNAMIC : p[2:0] ^ 3'h2;
            e[(7 - p) * 3 +: 3] = v;
            xfer({1'b0, p[2:0], v, 1'b1}, {1'b0, p[2:0], v, 1'b0});
            xfer({4'h0, p[2:0], 1'b1}, {4'h0, v, 1'b0});
        end
        xfer(8'h01, 8'h00);
        wb(1'b0, REG_CFG, 32'h0, q);
        check(q, {11'h0, e});
        wb(1'b0, REG_STATUS, 32'h0, q);
        check({30'h0, q[1:0]}, 32'h2);
        speed(2'h1, {5'h0E, 5'h0A, 5'h0A, 3'h3, 1'b1});
        speed(2'h2, {W1LT_OD_US, DSO_OD_US, W0R_BASE_US, 3'h0, 1'b1});
        wb(1'b1, REG_CTRL, 32'h3, q);
        wb(1'b0, REG_CTRL, 32'h0, q);
        check(q, 32'h2);
        speed(2'h0, {W1LT_BASE_US, DSO_BASE_US, W0R_BASE_US, 3'h0, 1'b1});
        cmd(ACC_CMD_CODE);
        $display("configuration test done");
    endtask
    task t_pass(input int e, input logic [3:0] dl);
        logic [7:0] hb, eb;
        logic [63:0] w;
        logic er, r0, r1, p, wv;
        int k, j, n;
        er = 1'b0;
        delay <= dl;
        for (n = 0; n < 64; n++) reads[2 * n +: 2] <= rd(n, e);
        cmd(CMD_DATA_MODE);
        xfer(8'hF0, 8'hF0);
        cmd(CMD_CMD_MODE);
        cmd(8'hB1);
        cmd(CMD_DATA_MODE);
        for (k = 0; k < 16; k++) begin
            hb = 8'h55;
            eb = 8'h00;
            for (j = 0; j < 4; j++) begin
                n = 4 * k + j;
                p = n[1];
                {r1, r0} = rd(n, e);
                er = er | (r0 & r1);
                wv = (r0 ^ r1) ? r0 : (r0 | p);
                w[n] = wv;
                hb[2 * j + 1] = p;
                eb[2 * j] = ~(r0 ^ r1);
                eb[2 * j + 1] = er | wv;
            end
            xfer(hb, eb);
        end
        cmd(CMD_CMD_MODE);
        cmd(ACC_CMD_CODE);
        if (e > 63) begin
            check(wrote[31:0], w[31:0]);
            check(wrote[63:32], w[63:32]);
        end
        $display("search pass done, error position %0d", e);
    endtask
    initial begin
        repeat (50000) @(posedge CLK_SYS);
        errors++;
        stop_test;
    end
    initial begin
        errors = 0;
        n_checks = 0;
        SYS_RST = 1'b1;
        {WB_CYC_I, WB_STB_I, WB_WE_I, RX_VALID, TX_READY} = 5'h0;
        {WB_ADR_I, RX_DATA, WB_DAT_I, reads} = '0;
        WB_SEL_I = 4'hF;
        delay = 4'h0;
        t_reset;
        t_pass(64, 4'h0);
        t_cfg;
        t_pass(40, 4'h3);
        // error-free pass repeated with a one cycle slave delay after the accelerator was turned off
        t_pass(64, 4'h1);
        t_reset;
        stop_test;
    end
endmodule
